// ---- logic/zx_ctrl.sv ----
// Zero-cross detector control: registers, sleep gating, event, pin, irq.
// Assumes an Avalon-MM host with waitrequest and a raw comparator level.
`timescale 1ns/1ps
module zx_ctrl
  import zx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Comparator and sleep state
  input wire logic cmpLevel,
  input wire logic [1:0] sleepMode,
  // Event, pin and interrupt
  output logic eventOut,
  output logic pinOut,
  output logic pinOe,
  output logic irqOut
);

  // ==========================================================
  // State
  typedef struct packed {
    logic runStandby;
    logic pinOutEn;
    logic invert;
    logic enable;
    zx_edge_type edgeSel;
    logic flag;
    logic irq;
    logic eventOut;
    logic pinOut;
    logic pinOe;
    logic waitReq;
    logic [31:0] readData;
  } zx_ctrl_state_type;

  zx_ctrl_state_type regs_q;
  zx_ctrl_state_type regs_d;

  zx_sleep_type sleepNow;
  logic syncOut;
  logic levelNow;
  logic stateBit;
  logic activeNow;
  logic edgeHit;
  logic [1:0] regIdx;
  logic request;
  logic accept;
  logic laneWr;
  logic ctrlWr;
  logic selWr;
  logic flagClrWr;
  logic flagZeroWr;
  logic [31:0] readMux;

  // ==========================================================
  // Sleep and enable gating
  assign sleepNow = zx_sleep_type'(sleepMode);

  always_comb begin
    unique case (sleepNow)
      SLEEP_ACTIVE: activeNow = regs_q.enable; // RULE11
      SLEEP_IDLE: activeNow = regs_q.enable; // RULE6
      SLEEP_STANDBY: activeNow = regs_q.enable && regs_q.runStandby; // RULE7
      SLEEP_POWER_DOWN: activeNow = 1'b0; // RULE8
    endcase
  end

  // ==========================================================
  // Synchronizer, polarity and edge qualifier
  zx_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(cmpLevel),
    .q(syncOut)
  );

  assign levelNow = syncOut ^ regs_q.invert; // RULE10 RULE14
  assign stateBit = activeNow && levelNow; // RULE12

  zx_edge u_edge (
    .clk(clk),
    .reset_n(reset_n),
    .level(levelNow), // RULE2
    .active(activeNow),
    .edgeSel(regs_q.edgeSel),
    .hit(edgeHit)
  );

  // ==========================================================
  // Bus decode
  assign regIdx = avs_address[ADDR_WORD_LSB+1:ADDR_WORD_LSB];
  assign request = avs_read || avs_write;
  assign accept = request && !regs_q.waitReq;
  assign laneWr = accept && avs_write && avs_byteenable[0];
  assign ctrlWr = laneWr && (regIdx == IDX_CONTROL_A);
  assign selWr = laneWr && (regIdx == IDX_INTERRUPT_CONTROL);
  assign flagClrWr = laneWr && (regIdx == IDX_DETECTOR_STATUS) &&
    avs_writedata[STAT_FLAG_BIT];
  assign flagZeroWr = laneWr && (regIdx == IDX_DETECTOR_STATUS) &&
    !avs_writedata[STAT_FLAG_BIT];

  always_comb begin
    readMux = '0;
    unique case (regIdx)
      IDX_CONTROL_A: begin
        readMux[CTRL_RUN_STANDBY_BIT] = regs_q.runStandby;
        readMux[CTRL_PIN_OE_BIT] = regs_q.pinOutEn;
        readMux[CTRL_INVERT_BIT] = regs_q.invert;
        readMux[CTRL_ENABLE_BIT] = regs_q.enable;
      end
      IDX_RESERVED_ONE: begin
        readMux = '0;
      end
      IDX_INTERRUPT_CONTROL: begin
        readMux[EDGE_SEL_LSB+1:EDGE_SEL_LSB] = regs_q.edgeSel;
      end
      IDX_DETECTOR_STATUS: begin
        readMux[STAT_LEVEL_BIT] = stateBit; // RULE12
        readMux[STAT_FLAG_BIT] = regs_q.flag;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    regs_d = regs_q;
    // One wait cycle, then the answer
    if (request && regs_q.waitReq) begin
      regs_d.waitReq = 1'b0;
      regs_d.readData = readMux;
    end else begin
      regs_d.waitReq = 1'b1;
    end
    if (ctrlWr) begin
      regs_d.runStandby = avs_writedata[CTRL_RUN_STANDBY_BIT];
      regs_d.pinOutEn = avs_writedata[CTRL_PIN_OE_BIT];
      regs_d.invert = avs_writedata[CTRL_INVERT_BIT];
      regs_d.enable = avs_writedata[CTRL_ENABLE_BIT];
    end
    if (selWr) begin
      regs_d.edgeSel =
        zx_edge_type'(avs_writedata[EDGE_SEL_LSB+1:EDGE_SEL_LSB]);
    end
    // Set wins over a clear in the same cycle
    if (edgeHit) begin
      regs_d.flag = 1'b1; // RULE3
    end else if (flagClrWr) begin
      regs_d.flag = 1'b0; // RULE13
    end
    regs_d.irq = regs_d.flag && (regs_d.edgeSel != EDGE_NONE); // RULE4
    regs_d.eventOut = activeNow && (cmpLevel ^ regs_q.invert); // RULE1
    regs_d.pinOe = activeNow && regs_q.pinOutEn; // RULE9
    regs_d.pinOut = regs_d.pinOe && (cmpLevel ^ regs_q.invert); // RULE9
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_q <= '0;
      regs_q.runStandby <= CONTROL_A_RESET[CTRL_RUN_STANDBY_BIT]; // RULE11
      regs_q.pinOutEn <= CONTROL_A_RESET[CTRL_PIN_OE_BIT];
      regs_q.invert <= CONTROL_A_RESET[CTRL_INVERT_BIT];
      regs_q.enable <= CONTROL_A_RESET[CTRL_ENABLE_BIT];
      regs_q.edgeSel <= zx_edge_type'(EDGE_SEL_RESET);
      regs_q.waitReq <= 1'b1;
      regs_q.readData <= READ_DATA_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = regs_q.readData;
  assign avs_waitrequest = regs_q.waitReq;
  assign eventOut = regs_q.eventOut;
  assign pinOut = regs_q.pinOut;
  assign pinOe = regs_q.pinOe;
  assign irqOut = regs_q.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  eventFollow_a: assert property ( // RULE1
    1'b1 |=> eventOut == $past(activeNow && (cmpLevel ^ regs_q.invert)))
    else $error("event output does not follow detector level");

  edgeInvert_a: assert property ( // RULE2
    activeNow && regs_q.edgeSel == EDGE_RISING && $rose(levelNow)
    |=> edgeHit)
    else $error("inverted rising edge not qualified");

  flagSet_a: assert property ( // RULE3
    edgeHit |=> regs_q.flag)
    else $error("qualified edge did not set crossing flag");

  irqHold_a: assert property ( // RULE4
    irqOut && !flagClrWr && !selWr |=> irqOut)
    else $error("interrupt request dropped before flag clear");

  irqMatch_a: assert property ( // RULE4
    irqOut == (regs_q.flag && regs_q.edgeSel != EDGE_NONE))
    else $error("interrupt request disagrees with flag and select");

  edgeNone_a: assert property ( // RULE5
    regs_q.edgeSel == EDGE_NONE |=> !edgeHit)
    else $error("edge seen with interrupts deselected");

  idleRun_a: assert property ( // RULE6
    sleepNow == SLEEP_IDLE && regs_q.enable && regs_q.pinOutEn
    |=> pinOe)
    else $error("pin output stopped in idle sleep");

  standbyOff_a: assert property ( // RULE7
    sleepNow == SLEEP_STANDBY && !regs_q.runStandby
    |=> !pinOe && !eventOut)
    else $error("detector active in standby without run bit");

  powerDown_a: assert property ( // RULE8
    sleepNow == SLEEP_POWER_DOWN |=> !pinOe && !pinOut && !eventOut)
    else $error("detector active in power-down");

  pinGate_a: assert property ( // RULE9
    !regs_q.pinOutEn |=> !pinOe && !pinOut)
    else $error("pin driven while pin output disabled");

  disabledQuiet_a: assert property ( // RULE11
    !regs_q.enable |=> !eventOut && !edgeHit)
    else $error("disabled detector produced activity");

  stateDelay_a: assert property ( // RULE12
    activeNow |-> stateBit == ($past(cmpLevel, 3) ^ regs_q.invert))
    else $error("state bit not three cycles behind comparator");

  flagClear_a: assert property ( // RULE13
    flagClrWr && !edgeHit |=> !regs_q.flag)
    else $error("writing one did not clear crossing flag");

  flagKeep_a: assert property ( // RULE13
    flagZeroWr && regs_q.flag |=> regs_q.flag)
    else $error("writing zero cleared crossing flag");

  statePol_a: assert property ( // RULE14
    activeNow && !regs_q.invert && syncOut |-> stateBit)
    else $error("state bit not one above reference");

  bothEdges_a: assert property ( // RULE15
    activeNow && regs_q.edgeSel == EDGE_BOTH && levelNow != $past(levelNow)
    |=> edgeHit)
    else $error("changed sample not counted as edge");

  flagStay_a: assert property ( // RULE13
    regs_q.flag && !flagClrWr |=> regs_q.flag)
    else $error("crossing flag lost without a clear");

  flagSource_a: assert property ( // RULE3
    !regs_q.flag && !edgeHit |=> !regs_q.flag)
    else $error("crossing flag set without a qualified edge");

  irqNone_a: assert property ( // RULE4
    regs_q.edgeSel == EDGE_NONE |-> !irqOut)
    else $error("interrupt request with interrupts deselected");

  pinFollow_a: assert property ( // RULE9
    pinOe |-> pinOut == eventOut)
    else $error("pin data differs from detector output");

  invertEvent_a: assert property ( // RULE10
    activeNow && regs_q.invert && !cmpLevel |=> eventOut)
    else $error("inverted low level not shown on event");

  fallEdge_a: assert property ( // RULE5
    activeNow && regs_q.edgeSel == EDGE_FALLING && $fell(levelNow)
    |=> edgeHit)
    else $error("falling edge not qualified");

  risingOnly_a: assert property ( // RULE5
    regs_q.edgeSel == EDGE_RISING && !$rose(levelNow)
    |=> !edgeHit)
    else $error("edge qualified without a rising sample");

  standbyRun_a: assert property ( // RULE7
    sleepNow == SLEEP_STANDBY && regs_q.runStandby && regs_q.enable &&
    regs_q.pinOutEn |=> pinOe)
    else $error("pin output stopped in standby with run bit");

  // ==========================================================
  // Covers
  flagRaised_c: cover property (!regs_q.flag ##1 regs_q.flag);
  irqBoth_c: cover property (regs_q.edgeSel == EDGE_BOTH && irqOut);
  standbyPin_c: cover property (sleepNow == SLEEP_STANDBY && pinOe);
  clearRace_c: cover property (flagClrWr && edgeHit);
  fallHit_c: cover property (regs_q.edgeSel == EDGE_FALLING && edgeHit);

endmodule

// ---- logic/zx_edge.sv ----
// Edge qualifier: compares consecutive synchronized output samples.
// Assumes the level input is already synchronized and inverted.
`timescale 1ns/1ps
module zx_edge
  import zx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Qualifier inputs
  input wire logic level,
  input wire logic active,
  input wire zx_edge_type edgeSel,
  // One-cycle qualifying edge
  output logic hit
);

  typedef struct packed {
    logic prev;
    logic hit;
  } zx_edge_state_type;

  zx_edge_state_type regs_q;
  zx_edge_state_type regs_d;
  logic rise;
  logic fall;

  // ==========================================================
  // Sample compare and mode select
  always_comb begin
    regs_d = regs_q;
    rise = level && !regs_q.prev; // RULE15
    fall = !level && regs_q.prev; // RULE15
    regs_d.prev = level;
    unique case (edgeSel) // RULE5
      EDGE_NONE: regs_d.hit = 1'b0;
      EDGE_RISING: regs_d.hit = active && rise;
      EDGE_FALLING: regs_d.hit = active && fall;
      EDGE_BOTH: regs_d.hit = active && (rise || fall);
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_q <= '0;
    end else begin
      regs_q <= regs_d;
    end
  end

  assign hit = regs_q.hit;

endmodule

// ---- logic/zx_pkg.sv ----
// Constants, field layout and types of the zero-cross detector control.
// Assumes a 20 MHz peripheral clock and an Avalon-MM register host.
// Function
// RULE1 - Comparator output drives a level event; no event inputs accepted.
// RULE2 - Interrupt edge qualified by edge select and the inversion bit.
// RULE3 - Selected interrupt condition sets the crossing flag.
// RULE4 - Interrupt request while edge select non-zero and flag set.
// RULE5 - Edge select: 0 none, 1 rising, 2 falling, 3 both.
// RULE6 - Idle sleep: detector runs exactly as in active mode.
// RULE7 - Standby: detector off unless run-in-standby bit is one.
// RULE8 - Power-down: detector disabled, pin output turned off.
// RULE9 - Pin output enable bit routes detector output to the pin.
// RULE10 - Inversion bit flips output before pin, event, status, interrupt.
// RULE11 - Detector runs only when enabled; control bits reset to zero.
// RULE12 - State bit shows output level through a three-cycle synchronizer.
// RULE13 - Writing one clears the crossing flag; writing zero is ignored.
// RULE14 - State bit is one above reference, zero below; inversion reverses.
// RULE15 - Edges found by comparing consecutive synchronized samples.
package zx_pkg;

  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [1:0] IDX_CONTROL_A = 2'h0;
  localparam logic [1:0] IDX_RESERVED_ONE = 2'h1;
  localparam logic [1:0] IDX_INTERRUPT_CONTROL = 2'h2;
  localparam logic [1:0] IDX_DETECTOR_STATUS = 2'h3;
  localparam int ADDR_WORD_LSB = 2;

  // ==========================================================
  // Field positions
  localparam int CTRL_RUN_STANDBY_BIT = 7;
  localparam int CTRL_PIN_OE_BIT = 6;
  localparam int CTRL_INVERT_BIT = 3;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int EDGE_SEL_LSB = 0;
  localparam int STAT_LEVEL_BIT = 4;
  localparam int STAT_FLAG_BIT = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  localparam logic [1:0] EDGE_SEL_RESET = 2'h0;
  localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISING,
    EDGE_FALLING,
    EDGE_BOTH
  } zx_edge_type;

  typedef enum logic [1:0] {
    SLEEP_ACTIVE,
    SLEEP_IDLE,
    SLEEP_STANDBY,
    SLEEP_POWER_DOWN
  } zx_sleep_type;

endpackage

// ---- logic/zx_sync.sv ----
// Multi-stage level synchronizer for the comparator output.
// Assumes an asynchronous input and a single destination clock.
`timescale 1ns/1ps
module zx_sync
  import zx_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Level in and out
  input wire logic d,
  output logic q
);

  typedef struct packed {
    logic [STAGES-1:0] stage;
  } zx_sync_state_type;

  zx_sync_state_type regs_q;
  zx_sync_state_type regs_d;

  // ==========================================================
  // Shift chain, one flop per stage
  always_comb begin
    regs_d = regs_q;
    regs_d.stage[0] = d;
    for (int i = 1; i < STAGES; i++) begin
      regs_d.stage[i] = regs_q.stage[i-1];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regs_q <= '0;
    end else begin
      regs_q <= regs_d;
    end
  end

  assign q = regs_q.stage[STAGES-1];

endmodule

// ---- verification/test_zero_cross_detect_ctrl.sv ----
// Self-checking bench of the zero-cross detector control.
// Assumes zx_ctrl, zx_pkg and the comparator model are compiled first.
`timescale 1ns/1ps
module test_zero_cross_detect_ctrl;
  import zx_pkg::*;
  logic clk, reset_n, avsRead, avsWrite, avsWait, cmpLevel, target, slow;
  logic eventOut, pinOut, pinOe, irqOut;
  logic [3:0] avsAddress, avsByteenable;
  logic [31:0] avsWritedata, avsReaddata;
  logic [1:0] sleepMode;
  int err_total, n_compared;

  // ==========================================================
  // Design and far side
  zx_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWait), .cmpLevel(cmpLevel), .sleepMode(sleepMode),
    .eventOut(eventOut), .pinOut(pinOut), .pinOe(pinOe), .irqOut(irqOut));
  zx_ac_source src (.clk(clk), .target(target), .slow(slow),
    .cmpLevel(cmpLevel));

  // ==========================================================
  // Shared tasks
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task xfer(input logic wr, input logic [1:0] idx, input logic [7:0] wd,
      output logic [7:0] rd);
    int n;
    @(posedge clk);
    avsAddress <= {idx, 2'h0};
    avsRead <= ~wr;
    avsWrite <= wr;
    avsWritedata <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWait !== 1'b0 && n < 40);
    chk(n < 40, 1'b1);
    rd = avsReaddata[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  task wrReg(input logic [1:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    xfer(1'b1, idx, wd, dummy);
  endtask

  task rdChk(input logic [1:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    xfer(1'b0, idx, 8'h00, got);
    chk(got, exp);
  endtask

  task lvl(input logic v);
    @(posedge clk);
    target <= v;
    repeat (12) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    chk({avsWait, irqOut, eventOut, pinOe}, 4'h8);
    @(posedge clk);
    reset_n <= 1'b1;
    rdChk(IDX_CONTROL_A, 8'h00);
    rdChk(IDX_INTERRUPT_CONTROL, 8'h00);
    rdChk(IDX_DETECTOR_STATUS, 8'h00);
    wrReg(IDX_RESERVED_ONE, 8'hFF);
    rdChk(IDX_RESERVED_ONE, 8'h00);
    avsByteenable <= 4'hE;
    wrReg(IDX_CONTROL_A, 8'hC9);
    avsByteenable <= 4'hF;
    rdChk(IDX_CONTROL_A, 8'h00);
    wrReg(IDX_CONTROL_A, 8'hC9);
    rdChk(IDX_CONTROL_A, 8'hC9);
    wrReg(IDX_INTERRUPT_CONTROL, 8'h03);
    rdChk(IDX_INTERRUPT_CONTROL, 8'h03);
  endtask

  task t_edges;
    logic v, hit;
    for (int inv = 0; inv < 2; inv++) begin
      for (int m = 0; m < 4; m++) begin
        wrReg(IDX_CONTROL_A, 8'h01 | 8'(inv << 3));
        wrReg(IDX_INTERRUPT_CONTROL, 8'(m));
        lvl(1'b0);
        wrReg(IDX_DETECTOR_STATUS, 8'h01);
        for (int s = 0; s < 2; s++) begin
          v = (s == 0);
          lvl(v);
          hit = (m == 3) || (m == 1 && (v ^ inv)) || (m == 2 && !(v ^ inv));
          rdChk(IDX_DETECTOR_STATUS, {3'h0, v ^ inv[0], 3'h0, hit});
          chk(irqOut, hit);
          chk(eventOut, v ^ inv[0]);
          wrReg(IDX_DETECTOR_STATUS, 8'h00);
          rdChk(IDX_DETECTOR_STATUS, {3'h0, v ^ inv[0], 3'h0, hit});
          wrReg(IDX_DETECTOR_STATUS, 8'h01);
          rdChk(IDX_DETECTOR_STATUS, {3'h0, v ^ inv[0], 4'h0});
          chk(irqOut, 1'b0);
        end
      end
    end
  endtask

  task t_pin;
    wrReg(IDX_CONTROL_A, 8'h41);
    lvl(1'b1);
    chk({pinOe, pinOut, eventOut}, 3'h7);
    rdChk(IDX_DETECTOR_STATUS, 8'h11);
    wrReg(IDX_CONTROL_A, 8'h49);
    repeat (4) @(posedge clk);
    chk({pinOe, pinOut, eventOut}, 3'h4);
    wrReg(IDX_CONTROL_A, 8'h01);
    repeat (4) @(posedge clk);
    chk({pinOe, eventOut}, 2'h1);
    wrReg(IDX_CONTROL_A, 8'h40);
    repeat (4) @(posedge clk);
    chk({pinOe, eventOut}, 2'h0);
    rdChk(IDX_DETECTOR_STATUS, 8'h01);
  endtask

  task t_sleep;
    logic act;
    slow <= 1'b1;
    wrReg(IDX_INTERRUPT_CONTROL, 8'h03);
    for (int s = 0; s < 4; s++) begin
      for (int run = 0; run < 2; run++) begin
        act = (s < 2) || (s == 2 && run == 1);
        wrReg(IDX_CONTROL_A, 8'h41 | 8'(run << 7));
        lvl(1'b0);
        wrReg(IDX_DETECTOR_STATUS, 8'h01);
        sleepMode <= 2'(s);
        lvl(1'b1);
        chk({eventOut, pinOe, pinOut, irqOut}, {4{act}});
        rdChk(IDX_DETECTOR_STATUS, {3'h0, act, 3'h0, act});
        sleepMode <= SLEEP_ACTIVE;
      end
    end
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #1000000;
    err_total++;
    results;
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    avsAddress = 4'h0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h00000000;
    avsByteenable = 4'hF;
    sleepMode = SLEEP_ACTIVE;
    target = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    t_reset;
    t_edges;
    t_pin;
    t_sleep;
    results;
  end
endmodule

// ---- verification/zx_ac_source.sv ----
// Model of the AC source, series resistor and comparator.
// Assumes the bench sets the wanted level; answers after one or two edges.
`timescale 1ns/1ps
module zx_ac_source (
  // Clock
  input wire logic clk,
  // Wanted level and response speed
  input wire logic target,
  input wire logic slow,
  // Comparator level seen by the detector
  output logic cmpLevel
);
  // ==========================================================
  // Level lag
  logic lag_q;
  initial begin
    lag_q = 1'b0;
    cmpLevel = 1'b0;
  end
  always @(posedge clk) begin
    lag_q <= target;
    cmpLevel <= slow ? lag_q : target;
  end
endmodule
